//--- pkg/jtag_tdr_pkg.sv
// Constants, tables and types shared by the test data register design.
package jtag_tdr_pkg;
  // Register lengths and the number of three-state pins in the chain.
  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int BSR_LEN = 46;
  localparam int NUM_OUT = 10;
  localparam int SYNC_W = BSR_LEN + 3;

  // Instruction codes.
  localparam logic [2:0] IR_EXTEST = 3'h0;
  localparam logic [2:0] IR_IDCODE = 3'h1;
  localparam logic [2:0] IR_SAMPLE = 3'h2;
  localparam logic [2:0] IR_CLAMP = 3'h3;
  localparam logic [2:0] IR_HIGHZ = 3'h4;
  localparam logic [2:0] IR_BYPASS = 3'h7;
  // Fixed pattern loaded into the instruction shift stage on capture.
  localparam logic [2:0] IR_CAPTURE = 3'h1;

  // Identification fields; maker, part and version values are arbitrary.
  localparam logic [3:0] ID_VERSION = 4'h0;
  localparam logic [15:0] ID_PART = 16'h1234;
  localparam logic [10:0] ID_MAKER = 11'h2a5;
  localparam logic [31:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

  // Cell of the internal signal with no package pin; it stays in the chain.
  localparam int CELL_UNBONDED = 22;

  // Three-state output cells in pin order: bit1, bit0, interrupt, sync, bits 7..2.
  localparam int OUT_CELL [NUM_OUT] = '{0, 2, 14, 25, 40, 41, 42, 43, 44, 45};
  // Control cell that enables each output cell above.
  localparam int CTRL_CELL [NUM_OUT] = '{1, 3, 15, 26, 1, 1, 1, 1, 1, 1};
  // Named cells of the chain used by the rest of the design.
  localparam int BUS_UPPER_ENABLE_CELL = 1;
  localparam int BUS_BIT0_ENABLE_CELL = 3;
  localparam int TRANSMIT_SYNC_ENABLE_CELL = 26;

  // Test access port controller states.
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPD_DR,
    SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
  } tap_state_t;
endpackage

//--- hw/boundary_chain.sv
// Boundary scan chain: 46 shift cells with a latched parallel stage.
`timescale 1ns/1ps
module boundary_chain (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic capture,
  input wire logic shift,
  input wire logic update,
  input wire logic serial_in,
  input wire logic [jtag_tdr_pkg::BSR_LEN-1:0] capture_in,
  output logic serial_out,
  output logic [jtag_tdr_pkg::BSR_LEN-1:0] latch
);
  logic [jtag_tdr_pkg::BSR_LEN-1:0] sr;
  logic [jtag_tdr_pkg::BSR_LEN-1:0] next_sr;
  logic [jtag_tdr_pkg::BSR_LEN-1:0] next_latch;
  logic [jtag_tdr_pkg::BSR_LEN:0] chain;

  // Serial data enters at the top cell and leaves from cell 0.
  assign chain[jtag_tdr_pkg::BSR_LEN] = serial_in;
  assign serial_out = sr[0];

  // Every cell, the unbonded one included, captures, shifts and latches alike.
  for (genvar i = 0; i < jtag_tdr_pkg::BSR_LEN; i++) begin : g_cell
    assign chain[i] = sr[i];
    always_comb begin
      next_sr[i] = sr[i];
      next_latch[i] = latch[i];
      if (capture) begin
        next_sr[i] = capture_in[i];
      end else if (shift) begin
        next_sr[i] = chain[i+1];
      end
      if (update) begin
        next_latch[i] = sr[i];
      end
    end
  end

  // The latched stage only moves on update so pins never see shifting data.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sr <= '0;
      latch <= '0;
    end else begin
      sr <= next_sr;
      latch <= next_latch;
    end
  end

  chk_chain_shift: assert property (@(posedge ref_clk) disable iff (reset)
    shift && !capture |=> sr == {$past(serial_in), $past(sr[jtag_tdr_pkg::BSR_LEN-1:1])})
    else $error("Boundary chain did not advance by one cell.");
  chk_chain_update: assert property (@(posedge ref_clk) disable iff (reset)
    !update |=> latch == $past(latch))
    else $error("Boundary latch changed outside update.");
endmodule

//--- hw/jtag_test_data_registers.sv
// Test access port with bypass, identification and boundary scan registers.
//
// What this block does
// - Bypass and boundary registers exist, plus an identification register.
// - Boundary register has a shift path and a separate latched parallel stage.
// - Bypass is one stage, used for BYPASS, CLAMP and HIGHZ.
// - Identification register is 32 shift stages plus 32 latched bits.
// - Identification register selected by IDCODE and in test-logic-reset.
// - Each three-state output cell is enabled by its assigned control cell.
// - Chain has exactly 46 cells; control cells capture core enables, other non-output cells observe pins.
// - Unbonded cell 22 stays in the chain and must be counted.
// - Instruction is three bits with the listed codes.
// - Identification value: LSB 1, 11-bit maker, 16-bit part, 4-bit version.
// - Identification value loads on the rising edge leaving capture-DR.
// - Shift-DR advances per rising edge; update-DR latches on falling edge.
`timescale 1ns/1ps
module jtag_test_data_registers (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic test_clock_pin,
  input wire logic test_mode_select_pin,
  input wire logic test_serial_in,
  output logic test_serial_out,
  output logic test_serial_out_en_n,
  input wire logic [jtag_tdr_pkg::BSR_LEN-1:0] observe_in,
  input wire logic [jtag_tdr_pkg::NUM_OUT-1:0] core_out,
  input wire logic [jtag_tdr_pkg::NUM_OUT-1:0] core_oe_n,
  output logic [jtag_tdr_pkg::NUM_OUT-1:0] pad_out,
  output logic [jtag_tdr_pkg::NUM_OUT-1:0] pad_oe_n
);
  localparam int SW = jtag_tdr_pkg::SYNC_W;

  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  logic [SW-1:0] sync3;
  logic [SW-1:0] stable;
  logic [SW-1:0] next_stable;
  logic tck;
  logic tms;
  logic tdi;
  logic [jtag_tdr_pkg::BSR_LEN-1:0] pins;
  logic tck_rise;
  logic tck_fall;
  jtag_tdr_pkg::tap_state_t state;
  jtag_tdr_pkg::tap_state_t next_state;
  logic [2:0] ir_sr;
  logic [2:0] next_ir_sr;
  logic [2:0] ir;
  logic [2:0] next_ir;
  logic [31:0] id_sr;
  logic [31:0] next_id_sr;
  logic [31:0] id_latch;
  logic [31:0] next_id_latch;
  logic byp;
  logic next_byp;
  logic next_tdo;
  logic next_tdo_en_n;
  logic [jtag_tdr_pkg::NUM_OUT-1:0] next_pad_out;
  logic [jtag_tdr_pkg::NUM_OUT-1:0] next_pad_oe_n;
  logic sel_bsr;
  logic sel_id;
  logic sel_byp;
  logic drive_from_chain;
  logic bsr_out;
  logic [jtag_tdr_pkg::BSR_LEN-1:0] bsr_latch;
  logic [jtag_tdr_pkg::BSR_LEN-1:0] capture_in;

  // Pins pass three flops; a level only counts once the last two agree,
  // which filters a single-sample glitch on the slow test clock.
  always_comb begin
    for (int b = 0; b < SW; b++) begin
      next_stable[b] = (sync2[b] == sync3[b]) ? sync3[b] : stable[b];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      stable <= '0;
    end else begin
      sync1 <= {test_clock_pin, test_mode_select_pin, test_serial_in, observe_in};
      sync2 <= sync1;
      sync3 <= sync2;
      stable <= next_stable;
    end
  end

  // Decoded test clock edges and the filtered control levels.
  assign tck = stable[SW-1];
  assign tms = stable[SW-2];
  assign tdi = stable[SW-3];
  assign pins = stable[jtag_tdr_pkg::BSR_LEN-1:0];
  assign tck_rise = next_stable[SW-1] && !tck;
  assign tck_fall = !next_stable[SW-1] && tck;

  // Register selection; unassigned codes fall back to bypass.
  assign sel_bsr = (ir == jtag_tdr_pkg::IR_EXTEST) || (ir == jtag_tdr_pkg::IR_SAMPLE);
  assign sel_id = (ir == jtag_tdr_pkg::IR_IDCODE);
  assign sel_byp = !sel_bsr && !sel_id;
  assign drive_from_chain = (ir == jtag_tdr_pkg::IR_EXTEST) || (ir == jtag_tdr_pkg::IR_CLAMP);

  // Control cells capture the core's own enables; every other cell observes a pin.
  always_comb begin
    capture_in = pins;
    for (int k = 0; k < jtag_tdr_pkg::NUM_OUT; k++) begin
      capture_in[jtag_tdr_pkg::CTRL_CELL[k]] = !core_oe_n[k];
    end
  end

  boundary_chain u_chain (
    .ref_clk(ref_clk),
    .reset(reset),
    .capture(tck_rise && sel_bsr && state == jtag_tdr_pkg::CAP_DR),
    .shift(tck_rise && sel_bsr && state == jtag_tdr_pkg::SHIFT_DR),
    .update(tck_fall && sel_bsr && state == jtag_tdr_pkg::UPD_DR),
    .serial_in(tdi),
    .capture_in(capture_in),
    .serial_out(bsr_out),
    .latch(bsr_latch)
  );

  // Controller transitions on each rising test clock edge.
  always_comb begin
    next_state = state;
    if (tck_rise) begin
      case (state)
        jtag_tdr_pkg::TLR: next_state = tms ? jtag_tdr_pkg::TLR : jtag_tdr_pkg::RTI;
        jtag_tdr_pkg::RTI: next_state = tms ? jtag_tdr_pkg::SEL_DR : jtag_tdr_pkg::RTI;
        jtag_tdr_pkg::SEL_DR: next_state = tms ? jtag_tdr_pkg::SEL_IR : jtag_tdr_pkg::CAP_DR;
        jtag_tdr_pkg::CAP_DR: next_state = tms ? jtag_tdr_pkg::EXIT1_DR : jtag_tdr_pkg::SHIFT_DR;
        jtag_tdr_pkg::SHIFT_DR: next_state = tms ? jtag_tdr_pkg::EXIT1_DR : jtag_tdr_pkg::SHIFT_DR;
        jtag_tdr_pkg::EXIT1_DR: next_state = tms ? jtag_tdr_pkg::UPD_DR : jtag_tdr_pkg::PAUSE_DR;
        jtag_tdr_pkg::PAUSE_DR: next_state = tms ? jtag_tdr_pkg::EXIT2_DR : jtag_tdr_pkg::PAUSE_DR;
        jtag_tdr_pkg::EXIT2_DR: next_state = tms ? jtag_tdr_pkg::UPD_DR : jtag_tdr_pkg::SHIFT_DR;
        jtag_tdr_pkg::UPD_DR: next_state = tms ? jtag_tdr_pkg::SEL_DR : jtag_tdr_pkg::RTI;
        jtag_tdr_pkg::SEL_IR: next_state = tms ? jtag_tdr_pkg::TLR : jtag_tdr_pkg::CAP_IR;
        jtag_tdr_pkg::CAP_IR: next_state = tms ? jtag_tdr_pkg::EXIT1_IR : jtag_tdr_pkg::SHIFT_IR;
        jtag_tdr_pkg::SHIFT_IR: next_state = tms ? jtag_tdr_pkg::EXIT1_IR : jtag_tdr_pkg::SHIFT_IR;
        jtag_tdr_pkg::EXIT1_IR: next_state = tms ? jtag_tdr_pkg::UPD_IR : jtag_tdr_pkg::PAUSE_IR;
        jtag_tdr_pkg::PAUSE_IR: next_state = tms ? jtag_tdr_pkg::EXIT2_IR : jtag_tdr_pkg::PAUSE_IR;
        jtag_tdr_pkg::EXIT2_IR: next_state = tms ? jtag_tdr_pkg::UPD_IR : jtag_tdr_pkg::SHIFT_IR;
        jtag_tdr_pkg::UPD_IR: next_state = tms ? jtag_tdr_pkg::SEL_DR : jtag_tdr_pkg::RTI;
        default: next_state = jtag_tdr_pkg::TLR;
      endcase
    end
  end

  // Instruction, identification and bypass stages; shifts move toward the output.
  always_comb begin
    next_ir_sr = ir_sr;
    next_ir = ir;
    next_id_sr = id_sr;
    next_id_latch = id_latch;
    next_byp = byp;
    if (tck_rise && state == jtag_tdr_pkg::CAP_IR) begin
      next_ir_sr = jtag_tdr_pkg::IR_CAPTURE;
    end else if (tck_rise && state == jtag_tdr_pkg::SHIFT_IR) begin
      next_ir_sr = {tdi, ir_sr[2:1]};
    end
    if (state == jtag_tdr_pkg::TLR) begin
      next_ir = jtag_tdr_pkg::IR_IDCODE;
    end else if (tck_fall && state == jtag_tdr_pkg::UPD_IR) begin
      next_ir = ir_sr;
    end
    if (tck_rise && sel_id && state == jtag_tdr_pkg::CAP_DR) begin
      next_id_sr = jtag_tdr_pkg::ID_VALUE;
    end else if (tck_rise && sel_id && state == jtag_tdr_pkg::SHIFT_DR) begin
      next_id_sr = {tdi, id_sr[31:1]};
    end
    if (tck_fall && sel_id && state == jtag_tdr_pkg::UPD_DR) begin
      next_id_latch = id_sr;
    end
    if (tck_rise && sel_byp && state == jtag_tdr_pkg::CAP_DR) begin
      next_byp = 1'b0;
    end else if (tck_rise && sel_byp && state == jtag_tdr_pkg::SHIFT_DR) begin
      next_byp = tdi;
    end
  end

  // Serial output changes on the falling edge so the far end samples a settled bit.
  always_comb begin
    next_tdo = test_serial_out;
    next_tdo_en_n = test_serial_out_en_n;
    if (tck_fall) begin
      next_tdo_en_n = !(state == jtag_tdr_pkg::SHIFT_IR || state == jtag_tdr_pkg::SHIFT_DR);
      if (state == jtag_tdr_pkg::SHIFT_IR) begin
        next_tdo = ir_sr[0];
      end else if (sel_bsr) begin
        next_tdo = bsr_out;
      end else if (sel_id) begin
        next_tdo = id_sr[0];
      end else begin
        next_tdo = byp;
      end
    end
  end

  // Pins follow the core unless a test instruction takes them over.
  always_comb begin
    for (int k = 0; k < jtag_tdr_pkg::NUM_OUT; k++) begin
      if (ir == jtag_tdr_pkg::IR_HIGHZ) begin
        next_pad_out[k] = core_out[k];
        next_pad_oe_n[k] = 1'b1;
      end else if (drive_from_chain) begin
        next_pad_out[k] = bsr_latch[jtag_tdr_pkg::OUT_CELL[k]];
        next_pad_oe_n[k] = !bsr_latch[jtag_tdr_pkg::CTRL_CELL[k]];
      end else begin
        next_pad_out[k] = core_out[k];
        next_pad_oe_n[k] = core_oe_n[k];
      end
    end
  end

  // All controller state registers; reset lands in test-logic-reset.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= jtag_tdr_pkg::TLR;
      ir_sr <= '0;
      ir <= jtag_tdr_pkg::IR_IDCODE;
      id_sr <= '0;
      id_latch <= '0;
      byp <= 1'b0;
      test_serial_out <= 1'b0;
      test_serial_out_en_n <= 1'b1;
      pad_out <= '0;
      pad_oe_n <= '1;
    end else begin
      state <= next_state;
      ir_sr <= next_ir_sr;
      ir <= next_ir;
      id_sr <= next_id_sr;
      id_latch <= next_id_latch;
      byp <= next_byp;
      test_serial_out <= next_tdo;
      test_serial_out_en_n <= next_tdo_en_n;
      pad_out <= next_pad_out;
      pad_oe_n <= next_pad_oe_n;
    end
  end

  sequence seq_id_capture;
    tck_rise && sel_id && state == jtag_tdr_pkg::CAP_DR;
  endsequence
  sequence seq_extest_held;
    (ir == jtag_tdr_pkg::IR_EXTEST) [*2];
  endsequence

  chk_reset_selects_id: assert property (@(posedge ref_clk) disable iff (reset)
    state == jtag_tdr_pkg::TLR |=> ir == jtag_tdr_pkg::IR_IDCODE && sel_id)
    else $error("Test-logic-reset did not select the identification register.");
  chk_id_capture: assert property (@(posedge ref_clk) disable iff (reset)
    seq_id_capture |=> id_sr == jtag_tdr_pkg::ID_VALUE && id_sr[0] == 1'b1)
    else $error("Identification value not loaded on capture.");
  chk_id_shift: assert property (@(posedge ref_clk) disable iff (reset)
    tck_rise && sel_id && state == jtag_tdr_pkg::SHIFT_DR |=> id_sr == {$past(tdi), $past(id_sr[31:1])})
    else $error("Identification register did not advance one stage.");
  chk_ir_update: assert property (@(posedge ref_clk) disable iff (reset)
    tck_fall && state == jtag_tdr_pkg::UPD_IR |=> ir == $past(ir_sr))
    else $error("Instruction not latched on update.");
  chk_bypass_path: assert property (@(posedge ref_clk) disable iff (reset)
    tck_rise && sel_byp && state == jtag_tdr_pkg::SHIFT_DR |=> byp == $past(tdi))
    else $error("Bypass stage did not take the serial input.");
  chk_highz_pins: assert property (@(posedge ref_clk) disable iff (reset)
    (ir == jtag_tdr_pkg::IR_HIGHZ) [*2] |-> pad_oe_n == '1 && sel_byp)
    else $error("HIGHZ left a pin driven.");
  chk_extest_enable: assert property (@(posedge ref_clk) disable iff (reset)
    seq_extest_held |-> pad_oe_n[3] == !$past(bsr_latch[jtag_tdr_pkg::TRANSMIT_SYNC_ENABLE_CELL])
      && pad_oe_n[1] == !$past(bsr_latch[jtag_tdr_pkg::BUS_BIT0_ENABLE_CELL])
      && pad_oe_n[9] == !$past(bsr_latch[jtag_tdr_pkg::BUS_UPPER_ENABLE_CELL]))
    else $error("Output enable does not follow its control cell.");
  chk_tdo_drive: assert property (@(posedge ref_clk) disable iff (reset)
    tck_fall && state == jtag_tdr_pkg::SHIFT_DR |=> !test_serial_out_en_n)
    else $error("Serial output not driven during shift.");
  // The identification latch is internal only, so this is the one place that watches it.
  chk_id_latch: assert property (@(posedge ref_clk) disable iff (reset)
    tck_fall && sel_id && state == jtag_tdr_pkg::UPD_DR |=> id_latch == $past(id_sr))
    else $error("Identification latch did not take the shift stage.");
endmodule

//--- sim/scan_controller_model.sv
// Behavioural boundary-scan controller that drives the test port pins.
`timescale 1ns/1ps
module scan_controller_model (
  output logic test_clock_pin,
  output logic test_mode_select_pin,
  output logic test_serial_in,
  input wire logic test_serial_out,
  input wire logic test_serial_out_en_n
);
  logic tdo_line;

  // The board pulls the data-out line up while the device releases it.
  assign tdo_line = test_serial_out_en_n ? 1'b1 : test_serial_out;

  // The test clock rests low between operations; it never runs free.
  initial begin
    test_clock_pin = 1'b0;
    test_mode_select_pin = 1'b1;
    test_serial_in = 1'b1;
  end

  // One 64 ns period; mode and data move at the fall, so both edges get 32 ns of margin.
  // Non-blocking updates keep a pin change that lands on a system clock edge free of races.
  task automatic tick(input logic ms, input logic di, output logic seen);
    test_mode_select_pin <= ms;
    test_serial_in <= di;
    #32;
    seen = tdo_line;
    test_clock_pin <= 1'b1;
    #32;
    test_clock_pin <= 1'b0;
  endtask

  // Five highs reach test-logic-reset from any state, then park in run-idle.
  task automatic tap_reset();
    logic s;
    repeat (5) tick(1'b1, 1'b1, s);
    tick(1'b0, 1'b1, s);
  endtask

  // Loads a three-bit instruction, least significant bit first, and returns the captured pattern.
  task automatic ir_scan(input logic [2:0] code, output logic [2:0] cap);
    logic s;
    tick(1'b1, 1'b1, s);
    tick(1'b1, 1'b1, s);
    tick(1'b0, 1'b1, s);
    tick(1'b0, 1'b1, s);
    for (int i = 0; i < 3; i++) tick(i == 2, code[i], cap[i]);
    tick(1'b1, 1'b1, s);
    tick(1'b0, 1'b1, s);
  endtask

  // Captures, shifts n bits of din through the selected register and updates it.
  task automatic dr_scan(input int n, input logic [63:0] din, output logic [63:0] dout);
    logic s;
    dout = '0;
    tick(1'b1, 1'b1, s);
    tick(1'b0, 1'b1, s);
    tick(1'b0, 1'b1, s);
    for (int i = 0; i < n; i++) tick(i == n - 1, din[i], dout[i]);
    tick(1'b1, 1'b1, s);
    tick(1'b0, 1'b1, s);
  endtask
endmodule

//--- sim/jtag_test_data_registers_tb.sv
// Self-checking bench for the test data registers behind the test access port.
`timescale 1ns/1ps
module jtag_test_data_registers_tb;
  localparam logic [22:0] HALF_PAT = 23'h54d553;
  logic ref_clk;
  logic reset;
  logic test_clock_pin;
  logic test_mode_select_pin;
  logic test_serial_in;
  logic test_serial_out;
  logic test_serial_out_en_n;
  logic [jtag_tdr_pkg::BSR_LEN-1:0] observe_in;
  logic [jtag_tdr_pkg::NUM_OUT-1:0] core_out;
  logic [jtag_tdr_pkg::NUM_OUT-1:0] core_oe_n;
  logic [jtag_tdr_pkg::NUM_OUT-1:0] pad_out;
  logic [jtag_tdr_pkg::NUM_OUT-1:0] pad_oe_n;
  logic [jtag_tdr_pkg::BSR_LEN-1:0] pat;
  int fails;
  int n_checks;

  jtag_test_data_registers DUT (.ref_clk(ref_clk), .reset(reset), .test_clock_pin(test_clock_pin),
    .test_mode_select_pin(test_mode_select_pin), .test_serial_in(test_serial_in),
    .test_serial_out(test_serial_out), .test_serial_out_en_n(test_serial_out_en_n),
    .observe_in(observe_in), .core_out(core_out), .core_oe_n(core_oe_n),
    .pad_out(pad_out), .pad_oe_n(pad_oe_n));

  scan_controller_model u_ctl (.test_clock_pin(test_clock_pin), .test_mode_select_pin(test_mode_select_pin),
    .test_serial_in(test_serial_in), .test_serial_out(test_serial_out),
    .test_serial_out_en_n(test_serial_out_en_n));

  // 200 MHz system clock.
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Counts one comparison and reports a mismatch at once.
  task automatic check(input string what, input logic [63:0] want, input logic [63:0] got);
    n_checks++;
    if (got !== want) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, want, got);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Pins under test control show the boundary latch; a control cell of 1 enables.
  task automatic check_pads_latch(input string what);
    logic [9:0] eo;
    logic [9:0] ee;
    for (int j = 0; j < jtag_tdr_pkg::NUM_OUT; j++) begin
      eo[j] = pat[jtag_tdr_pkg::OUT_CELL[j]];
      ee[j] = ~pat[jtag_tdr_pkg::CTRL_CELL[j]];
    end
    check(what, 64'({eo, ee}), 64'({pad_out, pad_oe_n}));
  endtask

  task automatic t_reset();
    repeat (3) @(posedge ref_clk);
    #1;
    check("serial out enable in reset", 64'h1, 64'(test_serial_out_en_n));
    check("pad enables in reset", 64'h3ff, 64'(pad_oe_n));
    @(posedge ref_clk);
    reset <= 1'b0;
    repeat (10) @(posedge ref_clk);
    #1;
    check("pads after reset", 64'({core_out, core_oe_n}), 64'({pad_out, pad_oe_n}));
    $display("test reset done");
  endtask

  // Reads the identification value straight after a controller reset; 64 shifts prove 32 stages.
  task automatic t_idcode();
    logic [63:0] din;
    logic [63:0] dout;
    din = 64'h0000_0000_c3a5_5a3c;
    u_ctl.tap_reset();
    u_ctl.dr_scan(64, din, dout);
    check("id value", 64'({jtag_tdr_pkg::ID_VERSION, jtag_tdr_pkg::ID_PART, jtag_tdr_pkg::ID_MAKER, 1'b1}),
      64'(dout[31:0]));
    check("id length", 64'(din[31:0]), 64'(dout[63:32]));
    $display("test idcode done");
  endtask

  // Samples the pins and preloads the chain; pins stay functional meanwhile.
  task automatic t_sample();
    logic [2:0] cap;
    logic [63:0] dout;
    logic [jtag_tdr_pkg::BSR_LEN-1:0] want;
    want = observe_in;
    for (int j = 0; j < jtag_tdr_pkg::NUM_OUT; j++) want[jtag_tdr_pkg::CTRL_CELL[j]] = ~core_oe_n[j];
    u_ctl.ir_scan(jtag_tdr_pkg::IR_SAMPLE, cap);
    check("ir capture", 64'h1, 64'(cap));
    u_ctl.dr_scan(48, {16'h0, pat, pat[1:0]}, dout);
    check("chain capture", 64'(want), 64'(dout[45:0]));
    check("unbonded cell", 64'(observe_in[jtag_tdr_pkg::CELL_UNBONDED]), 64'(dout[jtag_tdr_pkg::CELL_UNBONDED]));
    check("chain length", 64'(pat[1:0]), 64'(dout[47:46]));
    check("pads under sample", 64'({core_out, core_oe_n}), 64'({pad_out, pad_oe_n}));
    $display("test sample done");
  endtask

  // The preloaded latch reaches the pins only once the test-mode instruction is current.
  task automatic t_extest();
    logic [2:0] cap;
    u_ctl.ir_scan(jtag_tdr_pkg::IR_EXTEST, cap);
    check_pads_latch("extest pads");
    $display("test extest done");
  endtask

  // Every bypass-selecting code, reserved ones included: one stage that captures 0.
  task automatic t_bypass();
    logic [2:0] cap;
    logic [63:0] dout;
    logic [2:0] codes [5];
    codes = '{jtag_tdr_pkg::IR_CLAMP, jtag_tdr_pkg::IR_HIGHZ, jtag_tdr_pkg::IR_BYPASS, 3'h5, 3'h6};
    @(posedge ref_clk);
    core_out <= 10'h2c5;
    foreach (codes[k]) begin
      u_ctl.ir_scan(codes[k], cap);
      u_ctl.dr_scan(3, 64'h7, dout);
      check("bypass path", 64'h6, dout);
      if (codes[k] == jtag_tdr_pkg::IR_CLAMP) begin
        check_pads_latch("clamp pads");
      end else if (codes[k] == jtag_tdr_pkg::IR_HIGHZ) begin
        check("highz enables", 64'h3ff, 64'(pad_oe_n));
      end else begin
        check("functional pads", 64'({core_out, core_oe_n}), 64'({pad_out, pad_oe_n}));
      end
    end
    $display("test bypass done");
  endtask

  // Main sequence.
  initial begin
    fails = 0;
    n_checks = 0;
    reset = 1'b1;
    observe_in = 46'h1b3c_5a69_e2d7;
    core_out = 10'h13a;
    core_oe_n = 10'h00a;
    for (int i = 0; i < jtag_tdr_pkg::BSR_LEN; i++) pat[i] = HALF_PAT[i < 23 ? i : 45 - i];
    t_reset();
    t_idcode();
    t_sample();
    t_extest();
    t_bypass();
    t_idcode();
    summarize();
  end

  // Cuts a hang short well beyond the roughly 20 microseconds the scans take.
  initial begin
    #200000;
    fails++;
    $display("MISMATCH watchdog expected done seen timeout");
    summarize();
  end
endmodule
